// [design/pixel_proc_pkg.sv]
package pixel_proc_pkg;
   // Register offsets on the internal control bus
   localparam logic [15:0] RECTANGLE_COLOUR_OFFSET = 16'h4118;
   localparam logic [15:0] BITMAP_END_POINT_OFFSET = 16'h411c;
   localparam logic [15:0] BITMAP_START_POINT_OFFSET = 16'h4120;
   localparam logic [15:0] COMMAND_OPTIONS_OFFSET = 16'h4124;
   localparam logic [15:0] MEMORY_REQUEST_PRIORITY_OFFSET = 16'h4128;
   localparam logic [15:0] PACKET_WORD_COUNT_OFFSET = 16'h412c;
   localparam logic [15:0] READBACK_SELECT_OFFSET = 16'h4130;
   // Field positions
   localparam int COORD_W = 14;
   localparam int X_LSB = 16;
   localparam int Y_LSB = 0;
   localparam int USE_TARGET_LAYER_BIT = 28;
   localparam int TARGET_LAYER_LSB = 24;
   localparam int ANTIALIAS_ENABLE_BIT = 16;
   localparam int BITMAP_DIRECTION_BIT = 8;
   localparam int BITMAP_MIRROR_LSB = 0;
   localparam int COLOUR_W = 24;
   localparam int PRIORITY_W = 3;
   localparam int PACKET_W = 8;
   // Reset values
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   // Mirror select codes
   localparam logic [1:0] MIRROR_NONE = 2'h0;
   localparam logic [1:0] MIRROR_X = 2'h1;
   localparam logic [1:0] MIRROR_Y = 2'h2;
   localparam logic [1:0] MIRROR_XY = 2'h3;
   // Colour depth codes
   localparam logic [2:0] DEPTH_1BPP = 3'h0;
   localparam logic [2:0] DEPTH_2BPP = 3'h1;
   localparam logic [2:0] DEPTH_4BPP = 3'h2;
   localparam logic [2:0] DEPTH_8BPP = 3'h3;
   localparam logic [2:0] DEPTH_16BPP = 3'h4;
   // Drawing commands
   typedef enum logic [3:0] {
      no_operation_cmd,
      draw_line_cmd,
      draw_rectangle_cmd,
      draw_polygon_cmd,
      put_bitmap_cmd,
      put_compressed_bitmap_cmd,
      put_text_bitmap_cmd,
      put_text_compressed_cmd
   } command_type;
endpackage

// [design/bitmap_geometry.sv]
`timescale 1ns/1ps
`default_nettype none
// Registered end point, traversal and mirror decode for bitmap commands
module bitmap_geometry #(
   parameter int CW = 14
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic bitmap_cmd,
   input wire logic [CW-1:0] start_x,
   input wire logic [CW-1:0] start_y,
   input wire logic [CW-1:0] end_x,
   input wire logic [CW-1:0] end_y,
   input wire logic bitmap_direction,
   input wire logic [1:0] bitmap_mirror_select,
   output logic [CW-1:0] eff_end_x,
   output logic [CW-1:0] eff_end_y,
   output logic vertical,
   output logic mirror_x,
   output logic mirror_y
);
   wire logic swap;
   wire logic [CW-1:0] swap_x;
   wire logic [CW-1:0] swap_y;
   // Options only matter for bitmap commands
   assign swap = bitmap_cmd & bitmap_direction;
   // Wraps modulo the coordinate width, as the address counter would
   assign swap_x = CW'(start_x + end_y - start_y);
   assign swap_y = CW'(start_y + end_x - start_x);

   // Swapped end replaces the original, the unflipped shape is not drawn
   always_ff @(posedge clk) begin
      if (!rstn) begin
         eff_end_x <= '0;
         eff_end_y <= '0;
         vertical <= 1'b0;
         mirror_x <= 1'b0;
         mirror_y <= 1'b0;
      end else begin
         eff_end_x <= swap ? swap_x : end_x;
         eff_end_y <= swap ? swap_y : end_y;
         vertical <= swap;
         mirror_x <= bitmap_cmd & bitmap_mirror_select[0];
         mirror_y <= bitmap_cmd & bitmap_mirror_select[1];
      end
   end
endmodule
`default_nettype wire

// [design/packet_gate.sv]
`timescale 1ns/1ps
`default_nettype none
// Groups pushed words into packets of at most packet_word_count+1 words
module packet_gate #(
   parameter int PW = 8,
   parameter int QW = 3
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [PW-1:0] packet_word_count,
   input wire logic [QW-1:0] memory_request_priority,
   input wire logic word_push,
   input wire logic flush,
   output logic push_ready,
   output logic req_valid,
   output logic [PW:0] req_words,
   output logic [QW-1:0] req_priority,
   input wire logic req_ready
);
   logic [PW:0] pending;
   logic flush_pending;
   wire logic [PW:0] limit;
   wire logic full_packet;
   wire logic issue;
   wire logic accept_push;
   wire logic [PW:0] issue_words;
   wire logic [PW:0] next_pending;

   assign limit = {1'b0, packet_word_count} + (PW+1)'(1);
   assign full_packet = pending >= limit;
   // Remainders wait for a flush, so a short packet never goes out alone
   assign issue = !req_valid && (full_packet || ((flush_pending || flush) && pending != '0));
   assign issue_words = full_packet ? limit : pending;
   assign push_ready = pending != {1'b1, {PW{1'b0}}};
   assign accept_push = word_push & push_ready;
   assign next_pending = pending + (PW+1)'(accept_push) - (issue ? issue_words : '0);

   // Pending count and flush memory; a new flush wins over its own clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pending <= '0;
         flush_pending <= 1'b0;
      end else begin
         pending <= next_pending;
         flush_pending <= flush | (flush_pending & !(issue && !full_packet) & pending != '0);
      end
   end

   // Request stands until the controller takes it
   always_ff @(posedge clk) begin
      if (!rstn) begin
         req_valid <= 1'b0;
         req_words <= '0;
         req_priority <= '0;
      end else if (issue) begin
         req_valid <= 1'b1;
         req_words <= issue_words;
         req_priority <= memory_request_priority;
      end else if (req_ready) begin
         req_valid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [design/pixel_proc_bitmap_option_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module pixel_proc_bitmap_option_regs (
   input wire logic clk,
   input wire logic rstn,
   // Internal control bus
   input wire logic bus_sel,
   input wire logic bus_write,
   input wire logic [15:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   output logic [31:0] bus_rdata,
   output logic bus_ack,
   // Command sequencing from the drawing engine
   input wire logic cmd_start,
   input wire logic [3:0] cmd_code,
   input wire logic cmd_done,
   input wire logic [2:0] colour_depth,
   output logic cmd_busy,
   // Parameters applied to the running command
   output logic [23:0] draw_colour,
   output logic layer_valid,
   output logic [3:0] active_layer,
   output logic antialias_enable,
   output logic [13:0] start_x,
   output logic [13:0] start_y,
   output logic [13:0] eff_end_x,
   output logic [13:0] eff_end_y,
   output logic vertical,
   output logic mirror_x,
   output logic mirror_y,
   // Video memory controller side
   input wire logic word_push,
   output logic push_ready,
   output logic req_valid,
   output logic [8:0] req_words,
   output logic [2:0] req_priority,
   input wire logic req_ready
);
   localparam int CW = pixel_proc_pkg::COORD_W;
   localparam int XL = pixel_proc_pkg::X_LSB;
   localparam int YL = pixel_proc_pkg::Y_LSB;

   // Keeps only the bits that the colour depth uses
   function automatic logic [23:0] colour_mask(input logic [2:0] depth);
      case (depth)
         pixel_proc_pkg::DEPTH_1BPP: colour_mask = 24'h000001;
         pixel_proc_pkg::DEPTH_2BPP: colour_mask = 24'h000003;
         pixel_proc_pkg::DEPTH_4BPP: colour_mask = 24'h00000f;
         pixel_proc_pkg::DEPTH_8BPP: colour_mask = 24'h0000ff;
         pixel_proc_pkg::DEPTH_16BPP: colour_mask = 24'h00ffff;
         default: colour_mask = 24'hffffff;
      endcase
   endfunction

   // True for the four bitmap style commands
   function automatic logic is_bitmap(input logic [3:0] code);
      is_bitmap = code == 4'(pixel_proc_pkg::put_bitmap_cmd) ||
         code == 4'(pixel_proc_pkg::put_compressed_bitmap_cmd) ||
         code == 4'(pixel_proc_pkg::put_text_bitmap_cmd) ||
         code == 4'(pixel_proc_pkg::put_text_compressed_cmd);
   endfunction

   // Configuration registers, written by software
   logic [23:0] cfg_colour;
   logic [31:0] cfg_end;
   logic [31:0] cfg_start;
   logic [31:0] cfg_options;
   logic [2:0] cfg_priority;
   logic [7:0] cfg_packet;
   logic readback_select;
   // Buffered copies, owned by the command sequencer
   logic [23:0] buf_colour;
   logic [31:0] buf_end;
   logic [31:0] buf_start;
   logic [31:0] buf_options;
   logic [2:0] buf_priority;
   logic [7:0] buf_packet;
   logic running;
   logic [3:0] active_cmd;

   wire logic wr;
   wire logic wr_colour;
   wire logic wr_end;
   wire logic wr_start;
   wire logic wr_options;
   wire logic wr_priority;
   wire logic wr_packet;
   wire logic wr_readback;
   wire logic accept_cmd;
   wire logic bitmap_cmd;
   wire logic shape_cmd;
   wire logic [31:0] options_mask;
   wire logic [31:0] next_rdata;

   // Address decode
   assign wr = bus_sel & bus_write;
   assign wr_colour = wr && bus_addr == pixel_proc_pkg::RECTANGLE_COLOUR_OFFSET;
   assign wr_end = wr && bus_addr == pixel_proc_pkg::BITMAP_END_POINT_OFFSET;
   assign wr_start = wr && bus_addr == pixel_proc_pkg::BITMAP_START_POINT_OFFSET;
   assign wr_options = wr && bus_addr == pixel_proc_pkg::COMMAND_OPTIONS_OFFSET;
   assign wr_priority = wr && bus_addr == pixel_proc_pkg::MEMORY_REQUEST_PRIORITY_OFFSET;
   assign wr_packet = wr && bus_addr == pixel_proc_pkg::PACKET_WORD_COUNT_OFFSET;
   assign wr_readback = wr && bus_addr == pixel_proc_pkg::READBACK_SELECT_OFFSET;

   // Only the documented option fields are storable, the rest read zero
   assign options_mask = (32'h1 << pixel_proc_pkg::USE_TARGET_LAYER_BIT) |
      (32'hf << pixel_proc_pkg::TARGET_LAYER_LSB) |
      (32'h1 << pixel_proc_pkg::ANTIALIAS_ENABLE_BIT) |
      (32'h1 << pixel_proc_pkg::BITMAP_DIRECTION_BIT) |
      (32'h3 << pixel_proc_pkg::BITMAP_MIRROR_LSB);

   // Software side registers; reset to zero, update on the clock after a write
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cfg_colour <= pixel_proc_pkg::REG_RESET[23:0];
         cfg_end <= pixel_proc_pkg::REG_RESET;
         cfg_start <= pixel_proc_pkg::REG_RESET;
         cfg_options <= pixel_proc_pkg::REG_RESET;
         cfg_priority <= pixel_proc_pkg::REG_RESET[2:0];
         cfg_packet <= pixel_proc_pkg::REG_RESET[7:0];
         readback_select <= 1'b0;
      end else begin
         if (wr_colour) cfg_colour <= bus_wdata[23:0];
         if (wr_end) cfg_end <= bus_wdata & 32'h3fff_3fff;
         if (wr_start) cfg_start <= bus_wdata & 32'h3fff_3fff;
         if (wr_options) cfg_options <= bus_wdata & options_mask;
         if (wr_priority) cfg_priority <= bus_wdata[2:0];
         if (wr_packet) cfg_packet <= bus_wdata[7:0];
         if (wr_readback) readback_select <= bus_wdata[0];
      end
   end

   // A new command is taken only when idle; a no-op flushes and loads the buffers but does not set busy
   assign accept_cmd = cmd_start & !running;

   // Buffered copies load at command start and stay fixed while running
   always_ff @(posedge clk) begin
      if (!rstn) begin
         buf_colour <= '0;
         buf_end <= '0;
         buf_start <= '0;
         buf_options <= '0;
         buf_priority <= '0;
         buf_packet <= '0;
         active_cmd <= '0;
      end else if (accept_cmd) begin
         buf_colour <= cfg_colour;
         buf_end <= cfg_end;
         buf_start <= cfg_start;
         buf_options <= cfg_options;
         buf_priority <= cfg_priority;
         buf_packet <= cfg_packet;
         active_cmd <= cmd_code;
      end
   end

   // Busy from acceptance of a drawing command until the engine reports done
   always_ff @(posedge clk) begin
      if (!rstn) begin
         running <= 1'b0;
      end else if (accept_cmd) begin
         running <= cmd_code != 4'(pixel_proc_pkg::no_operation_cmd);
      end else if (cmd_done) begin
         running <= 1'b0;
      end
   end
   assign cmd_busy = running;

   // Read mux; double buffered values follow the readback select
   assign next_rdata =
      bus_addr == pixel_proc_pkg::RECTANGLE_COLOUR_OFFSET ?
         {8'h00, readback_select ? cfg_colour : buf_colour} :
      bus_addr == pixel_proc_pkg::BITMAP_END_POINT_OFFSET ?
         (readback_select ? cfg_end : buf_end) :
      bus_addr == pixel_proc_pkg::BITMAP_START_POINT_OFFSET ?
         (readback_select ? cfg_start : buf_start) :
      bus_addr == pixel_proc_pkg::COMMAND_OPTIONS_OFFSET ?
         (readback_select ? cfg_options : buf_options) :
      bus_addr == pixel_proc_pkg::MEMORY_REQUEST_PRIORITY_OFFSET ?
         {29'h0, readback_select ? cfg_priority : buf_priority} :
      bus_addr == pixel_proc_pkg::PACKET_WORD_COUNT_OFFSET ?
         {24'h0, readback_select ? cfg_packet : buf_packet} :
      bus_addr == pixel_proc_pkg::READBACK_SELECT_OFFSET ?
         {31'h0, readback_select} : 32'h0;

   // Reads are answered one clock after the select, unmapped reads give zero
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bus_rdata <= '0;
         bus_ack <= 1'b0;
      end else begin
         bus_ack <= bus_sel;
         bus_rdata <= (bus_sel && !bus_write) ? next_rdata : '0;
      end
   end

   // Command class decode from the latched command
   assign bitmap_cmd = running & is_bitmap(active_cmd);
   assign shape_cmd = running && (active_cmd == 4'(pixel_proc_pkg::draw_line_cmd) ||
      active_cmd == 4'(pixel_proc_pkg::draw_rectangle_cmd) ||
      active_cmd == 4'(pixel_proc_pkg::draw_polygon_cmd));

   // Outputs that follow the buffered copy for the running command
   always_ff @(posedge clk) begin
      if (!rstn) begin
         draw_colour <= '0;
         layer_valid <= 1'b0;
         active_layer <= '0;
         antialias_enable <= 1'b0;
         start_x <= '0;
         start_y <= '0;
      end else begin
         draw_colour <= (running && active_cmd == 4'(pixel_proc_pkg::draw_rectangle_cmd)) ?
            buf_colour & colour_mask(colour_depth) : '0;
         layer_valid <= bitmap_cmd | (shape_cmd & buf_options[pixel_proc_pkg::USE_TARGET_LAYER_BIT]);
         active_layer <= buf_options[pixel_proc_pkg::TARGET_LAYER_LSB +: 4];
         antialias_enable <= buf_options[pixel_proc_pkg::ANTIALIAS_ENABLE_BIT];
         start_x <= buf_start[XL +: CW];
         start_y <= buf_start[YL +: CW];
      end
   end

   // End point, traversal and mirror axes; the swapped end replaces the original
   bitmap_geometry #(.CW(CW)) geometry (
      .clk(clk),
      .rstn(rstn),
      .bitmap_cmd(bitmap_cmd),
      .start_x(buf_start[XL +: CW]),
      .start_y(buf_start[YL +: CW]),
      .end_x(buf_end[XL +: CW]),
      .end_y(buf_end[YL +: CW]),
      .bitmap_direction(buf_options[pixel_proc_pkg::BITMAP_DIRECTION_BIT]),
      .bitmap_mirror_select(buf_options[pixel_proc_pkg::BITMAP_MIRROR_LSB +: 2]),
      .eff_end_x(eff_end_x),
      .eff_end_y(eff_end_y),
      .vertical(vertical),
      .mirror_x(mirror_x),
      .mirror_y(mirror_y)
   );

   // Packetising toward the video memory controller; command start flushes
   packet_gate #(.PW(pixel_proc_pkg::PACKET_W), .QW(pixel_proc_pkg::PRIORITY_W)) packets (
      .clk(clk),
      .rstn(rstn),
      .packet_word_count(buf_packet),
      .memory_request_priority(buf_priority),
      .word_push(word_push),
      .flush(accept_cmd),
      .push_ready(push_ready),
      .req_valid(req_valid),
      .req_words(req_words),
      .req_priority(req_priority),
      .req_ready(req_ready)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_start_idle;
      cmd_start && !running;
   endsequence

   a_write_lands: assert property (wr_colour |=> cfg_colour == $past(bus_wdata[23:0]))
      else $error("colour write not stored");
   a_buffer_frozen: assert property (running && !accept_cmd |=> $stable(buf_options) && $stable(buf_end))
      else $error("buffer changed while running");
   // Every accepted start copies the written values, not only right after a write
   a_buffer_loads: assert property (s_start_idle |=> buf_options == $past(cfg_options) && buf_end == $past(cfg_end))
      else $error("buffer not loaded at start");
   a_readback_config: assert property (bus_sel && !bus_write && readback_select &&
      bus_addr == pixel_proc_pkg::COMMAND_OPTIONS_OFFSET |=> bus_rdata == $past(cfg_options))
      else $error("config readback wrong");
   a_readback_buffer: assert property (bus_sel && !bus_write && !readback_select &&
      bus_addr == pixel_proc_pkg::BITMAP_END_POINT_OFFSET |=> bus_rdata == $past(buf_end))
      else $error("buffered readback wrong");
   a_packet_bound: assert property (req_valid |-> req_words <= {1'b0, buf_packet} + 9'h1 && req_words != 9'h0)
      else $error("packet too large or empty");
   a_layer_shape: assert property (shape_cmd && !buf_options[pixel_proc_pkg::USE_TARGET_LAYER_BIT] |=> !layer_valid)
      else $error("layer used without flag");
   a_layer_bitmap: assert property (bitmap_cmd |=> layer_valid)
      else $error("bitmap command lost layer");
   // The command must still run in the second cycle, else the geometry falls back to the plain end
   a_swap_end: assert property (bitmap_cmd && buf_options[pixel_proc_pkg::BITMAP_DIRECTION_BIT]
      ##1 bitmap_cmd |=> eff_end_x == CW'(start_x + $past(buf_end[YL +: CW], 2) - start_y))
      else $error("swapped end point wrong");
   a_mirror_gate: assert property (!bitmap_cmd |=> !mirror_x && !mirror_y && !vertical)
      else $error("mirror outside bitmap command");
   a_colour_depth: assert property (colour_depth == pixel_proc_pkg::DEPTH_1BPP ##1
      colour_depth == pixel_proc_pkg::DEPTH_1BPP |-> draw_colour[23:1] == 23'h0)
      else $error("colour exceeds depth");
   // A flush remembered behind a stalled request may release a short packet much later
   a_no_short_packet: assert property (req_valid && !$past(req_valid) && !$past(accept_cmd) &&
      !$past(packets.flush_pending) |-> req_words == {1'b0, buf_packet} + 9'h1)
      else $error("short packet without flush");
endmodule
`default_nettype wire

// [test/vram_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Video memory controller stand-in: takes one packet request at a time
module vram_ctrl_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic req_valid,
   output logic req_ready
);
   int wait_cnt;
   // Random stall of 0..3 cycles, so prompt and slow grants both occur
   always @(posedge clk) begin
      if (!rstn || req_ready) begin
         req_ready <= 1'b0;
         wait_cnt <= $urandom_range(3, 0);
      end else if (req_valid) begin
         if (wait_cnt == 0)
            req_ready <= 1'b1;
         else
            wait_cnt <= wait_cnt - 1;
      end
   end
endmodule
`default_nettype wire

// [test/pixel_proc_bitmap_option_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module pixel_proc_bitmap_option_regs_tb;
   logic clk, rstn, bus_sel, bus_write, bus_ack, cmd_start, cmd_done, cmd_busy, layer_valid, antialias_enable;
   logic vertical, mirror_x, mirror_y, word_push, push_ready, req_valid, req_ready;
   logic [15:0] bus_addr;
   logic [31:0] bus_wdata, bus_rdata;
   logic [3:0] cmd_code, active_layer;
   logic [2:0] colour_depth, req_priority;
   logic [23:0] draw_colour;
   logic [13:0] start_x, start_y, eff_end_x, eff_end_y;
   logic [8:0] req_words;
   // Model state: written registers and the copies taken at command start
   logic [31:0] cfg[7], buff[7];
   localparam logic [31:0] MASK[7] = '{32'hffffff, 32'h3fff3fff, 32'h3fff3fff, 32'h1f010103, 32'h7, 32'hff, 32'h1};
   int bad_count, cmp_count, pend, n;
   int expq[$];

   pixel_proc_bitmap_option_regs i_pixel_proc_bitmap_option_regs (.clk, .rstn, .bus_sel, .bus_write, .bus_addr,
      .bus_wdata, .bus_rdata, .bus_ack, .cmd_start, .cmd_code, .cmd_done, .colour_depth, .cmd_busy, .draw_colour,
      .layer_valid, .active_layer, .antialias_enable, .start_x, .start_y, .eff_end_x, .eff_end_y, .vertical,
      .mirror_x, .mirror_y, .word_push, .push_ready, .req_valid, .req_ready, .req_words, .req_priority);
   vram_ctrl_model i_vram_ctrl_model (.clk, .rstn, .req_valid, .req_ready);

   // Clock and a watchdog well beyond the expected run
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #100000;
      bad_count++;
      report_and_stop();
   end

   task automatic report_and_stop();
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One bus access; index 7 lands on an unmapped word
   task automatic bus(input logic wr, input int i, input logic [31:0] d);
      @(posedge clk);
      bus_sel <= 1'b1;
      bus_write <= wr;
      bus_addr <= pixel_proc_pkg::RECTANGLE_COLOUR_OFFSET + 16'(4 * i);
      bus_wdata <= d;
      @(posedge clk);
      bus_sel <= 1'b0;
      #1;
      `CHECK(bus_ack, 1'b1)
      if (wr && i < 7)
         cfg[i] = d & MASK[i];
      else if (!wr)
         `CHECK(bus_rdata, i > 6 ? 32'h0 : (i == 6 || cfg[6][0]) ? cfg[i] : buff[i])
   endtask

   // Start a command, check what it applies, then finish it unless it is a no-op
   task automatic run_cmd(input logic [3:0] c);
      logic bm, dir;
      logic [31:0] o, s, e;
      logic [23:0] dm;
      @(posedge clk);
      cmd_start <= 1'b1;
      cmd_code <= c;
      colour_depth <= 3'($urandom_range(5, 0));
      @(posedge clk);
      cmd_start <= 1'b0;
      buff = cfg;
      if (pend > 0)
         expq.push_back(pend);
      pend = 0;
      o = buff[3];
      s = buff[2];
      e = buff[1];
      bm = c[2];
      dir = bm & o[8];
      dm = colour_depth < 5 ? 24'((1 << (1 << colour_depth)) - 1) : 24'hffffff;
      repeat (3) @(posedge clk);
      #1;
      `CHECK(cmd_busy, c != 4'h0)
      `CHECK(layer_valid, bm | (c != 4'h0 && o[28]))
      `CHECK({active_layer, antialias_enable}, {o[27:24], o[16]})
      `CHECK({start_x, start_y}, {s[29:16], s[13:0]})
      `CHECK(eff_end_x, dir ? 14'(s[29:16] + e[13:0] - s[13:0]) : e[29:16])
      `CHECK(eff_end_y, dir ? 14'(s[13:0] + e[29:16] - s[29:16]) : e[13:0])
      `CHECK({vertical, mirror_x, mirror_y}, {dir, bm & o[0], bm & o[1]})
      `CHECK(draw_colour, c == 4'h2 ? buff[0][23:0] & dm : 24'h0)
      if (c != 4'h0) begin
         bus(1'b1, 2, $urandom);
         `CHECK(start_x, s[29:16])
         @(posedge clk);
         cmd_done <= 1'b1;
         @(posedge clk);
         cmd_done <= 1'b0;
         #1;
         `CHECK(cmd_busy, 1'b0)
      end
   endtask

   // Every granted packet must match the next expected size
   always @(posedge clk) begin
      if (rstn && req_valid && req_ready) begin
         n = expq.size() ? expq.pop_front() : 0;
         `CHECK(req_words, 9'(n))
         `CHECK(req_priority, buff[4][2:0])
      end
   end

   initial begin
      {rstn, bus_sel, bus_write, cmd_start, cmd_done, word_push} = '0;
      bus_addr = '0;
      bus_wdata = '0;
      cmd_code = '0;
      colour_depth = '0;
      cfg = '{default: '0};
      buff = '{default: '0};
      pend = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      void'($urandom(11410));
      for (int i = 0; i < 8; i++)
         bus(1'b0, i, 0);
      bus(1'b1, 6, 1);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, i, $urandom);
         bus(1'b0, i, 0);
      end
      bus(1'b1, 6, 0);
      bus(1'b0, 0, 0);
      // Walk all command codes and mirror codes with random geometry
      for (int k = 0; k < 16; k++) begin
         // Layer flag and direction are forced both ways; the layer flag follows the command's low bit, so each shape command sees one setting
         bus(1'b1, 3, ($urandom & 32'heffffefc) | (32'(k % 2) << 28) | (32'(k / 8) << 8) | 32'(k % 4));
         bus(1'b1, 0, $urandom);
         bus(1'b1, 1, $urandom);
         bus(1'b1, 2, $urandom);
         run_cmd(4'(k % 8));
         bus(1'b0, 3, 0);
      end
      // Two-word packets, then the leftover word goes out on a no-op
      bus(1'b1, 5, 1);
      bus(1'b1, 4, $urandom);
      run_cmd(4'h0);
      @(posedge clk);
      word_push <= 1'b1;
      repeat (5) begin
         @(posedge clk);
         `CHECK(push_ready, 1'b1)
         pend++;
         if (pend == 2) begin
            expq.push_back(2);
            pend = 0;
         end
      end
      word_push <= 1'b0;
      repeat (12) @(posedge clk);
      `CHECK(expq.size(), 0)
      run_cmd(4'h0);
      repeat (12) @(posedge clk);
      `CHECK(expq.size(), 0)
      report_and_stop();
   end
endmodule
`default_nettype wire
